// ===== rtl/cpx_pkg.sv
// Package of register map, field layout and encodings for the power-down and extra-lane block
package cpx_pkg;

	// ==========================================================
	// Bus geometry
	localparam int unsigned ADDR_W = 12;
	localparam int unsigned DATA_W = 32;
	localparam int unsigned STRB_W = DATA_W / 8;
	localparam int unsigned REG_W  = 8;

	// ==========================================================
	// Register indices and byte addresses (byte address = 4 x index)
	localparam logic [ADDR_W-1:0] IDX_CHAN_PD     = 12'h209;
	localparam logic [ADDR_W-1:0] IDX_EXTRA_A     = 12'h20a;
	localparam logic [ADDR_W-1:0] IDX_STATUS      = 12'h20c;
	localparam logic [ADDR_W-1:0] ADDR_CHAN_PD    = {IDX_CHAN_PD[ADDR_W-3:0], 2'b00};
	localparam logic [ADDR_W-1:0] ADDR_EXTRA_A    = {IDX_EXTRA_A[ADDR_W-3:0], 2'b00};
	localparam logic [ADDR_W-1:0] ADDR_STATUS     = {IDX_STATUS[ADDR_W-3:0], 2'b00};

	// ==========================================================
	// Field positions
	localparam int unsigned PD_CHAN_A_BIT     = 0;
	localparam int unsigned PD_CHAN_B_BIT     = 1;
	localparam int unsigned EXTRA_SER_BIT     = 0;
	localparam int unsigned STAT_SUBSYS_BIT   = 0;
	localparam int unsigned STAT_B_UNDEF_BIT  = 1;
	localparam int unsigned STAT_LATE_WR_BIT  = 2;

	// ==========================================================
	// Reset values
	localparam logic [REG_W-1:0] CHAN_PD_RST  = 8'h00;
	localparam logic [REG_W-1:0] EXTRA_A_RST  = 8'h00;

	// ==========================================================
	// Link test select codes
	localparam int unsigned       TEST_W         = 5;
	localparam logic [TEST_W-1:0] TEST_NORMAL    = 5'h00;
	localparam logic [TEST_W-1:0] TEST_ALT_DATA  = 5'h05;
	localparam logic [TEST_W-1:0] TEST_RAMP      = 5'h04;

	// ==========================================================
	// Bus responses
	localparam logic [1:0] RESP_OKAY   = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;

endpackage : cpx_pkg

// ===== rtl/cpx_lane_gate.sv
// One serial lane: clock gating and test-pattern choice
module cpx_lane_gate
	import cpx_pkg::*;
(
	// Lane requests
	input  wire logic                      modeUsed,
	input  wire logic                      extraLane,
	input  wire logic                      extraSer,
	input  wire logic                      subsysPd,
	input  wire logic [cpx_pkg::TEST_W-1:0] testSel,
	// Serializer clock chain
	input  wire logic                      lowerSerOk,
	output logic                           serOkOut,
	// Next values
	output logic                           linkClkNext,
	output logic                           serClkNext,
	output logic [cpx_pkg::TEST_W-1:0]     testNext
);
	logic serWanted;
	logic extraOnly;

	assign serWanted   = modeUsed | (extraLane & extraSer);
	assign serOkOut    = serWanted & lowerSerOk;
	assign serClkNext  = serOkOut & ~subsysPd;
	assign linkClkNext = (modeUsed | extraLane) & ~subsysPd;
	assign extraOnly   = extraLane & ~modeUsed;
	// Extra-only lanes send a ramp instead of undefined sample data
	assign testNext    = (extraOnly && (testSel == TEST_NORMAL || testSel == TEST_ALT_DATA))
	                     ? TEST_RAMP : testSel;

endmodule : cpx_lane_gate

// ===== rtl/cpx_axil_slave.sv
// AXI4-Lite slave front end: one write and one read in flight
module cpx_axil_slave
	import cpx_pkg::*;
(
	// Clock and reset
	input  wire logic                        core_clk,
	input  wire logic                        rst_n,
	// Write address and data
	input  wire logic [cpx_pkg::ADDR_W-1:0]  s_axil_awaddr,
	input  wire logic                        s_axil_awvalid,
	output logic                             s_axil_awready,
	input  wire logic [cpx_pkg::DATA_W-1:0]  s_axil_wdata,
	input  wire logic [cpx_pkg::STRB_W-1:0]  s_axil_wstrb,
	input  wire logic                        s_axil_wvalid,
	output logic                             s_axil_wready,
	// Write response
	output logic [1:0]                       s_axil_bresp,
	output logic                             s_axil_bvalid,
	input  wire logic                        s_axil_bready,
	// Read address and data
	input  wire logic [cpx_pkg::ADDR_W-1:0]  s_axil_araddr,
	input  wire logic                        s_axil_arvalid,
	output logic                             s_axil_arready,
	output logic [cpx_pkg::DATA_W-1:0]       s_axil_rdata,
	output logic [1:0]                       s_axil_rresp,
	output logic                             s_axil_rvalid,
	input  wire logic                        s_axil_rready,
	// Register file side
	output logic                             wrEn,
	output logic [cpx_pkg::ADDR_W-1:0]       wrAddr,
	output logic [cpx_pkg::DATA_W-1:0]       wrData,
	output logic [cpx_pkg::STRB_W-1:0]       wrStrb,
	input  wire logic                        wrHit,
	output logic [cpx_pkg::ADDR_W-1:0]       rdAddr,
	input  wire logic [cpx_pkg::DATA_W-1:0]  rdData,
	input  wire logic                        rdHit
);
	logic awHeld_reg;
	logic wHeld_reg;
	logic arHeld_reg;

	assign wrEn           = awHeld_reg & wHeld_reg;

	// ==========================================================
	// Write channel
	always_ff @(posedge core_clk) begin
		if (!rst_n) begin
			awHeld_reg    <= 1'b0;
			wHeld_reg     <= 1'b0;
			wrAddr        <= '0;
			wrData        <= '0;
			wrStrb        <= '0;
			s_axil_bvalid <= 1'b0;
			s_axil_bresp  <= RESP_OKAY;
			// Readies are flops, high while idle
			s_axil_awready <= 1'b1;
			s_axil_wready  <= 1'b1;
		end else begin
			if (s_axil_awvalid && s_axil_awready) begin
				awHeld_reg     <= 1'b1;
				wrAddr         <= s_axil_awaddr;
				s_axil_awready <= 1'b0;
			end
			if (s_axil_wvalid && s_axil_wready) begin
				wHeld_reg     <= 1'b1;
				wrData        <= s_axil_wdata;
				wrStrb        <= s_axil_wstrb;
				s_axil_wready <= 1'b0;
			end
			if (wrEn) begin
				awHeld_reg    <= 1'b0;
				wHeld_reg     <= 1'b0;
				s_axil_bvalid <= 1'b1;
				s_axil_bresp  <= wrHit ? RESP_OKAY : RESP_SLVERR;
			end else if (s_axil_bready) begin
				s_axil_bvalid <= 1'b0;
				if (s_axil_bvalid) begin
					s_axil_awready <= 1'b1;
					s_axil_wready  <= 1'b1;
				end
			end
		end
	end

	// ==========================================================
	// Read channel
	always_ff @(posedge core_clk) begin
		if (!rst_n) begin
			arHeld_reg    <= 1'b0;
			rdAddr        <= '0;
			s_axil_rvalid <= 1'b0;
			s_axil_rdata  <= '0;
			s_axil_rresp  <= RESP_OKAY;
			s_axil_arready <= 1'b1;
		end else begin
			if (s_axil_arvalid && s_axil_arready) begin
				arHeld_reg     <= 1'b1;
				rdAddr         <= s_axil_araddr;
				s_axil_arready <= 1'b0;
			end
			if (arHeld_reg) begin
				arHeld_reg    <= 1'b0;
				s_axil_rvalid <= 1'b1;
				s_axil_rdata  <= rdHit ? rdData : '0;
				s_axil_rresp  <= rdHit ? RESP_OKAY : RESP_SLVERR;
			end else if (s_axil_rready) begin
				s_axil_rvalid <= 1'b0;
				if (s_axil_rvalid) begin
					s_axil_arready <= 1'b1;
				end
			end
		end
	end

endmodule : cpx_axil_slave

// ===== rtl/cpx_top.sv
// Channel power-down and extra-lane enable register bank with clock and power gating
module cpx_top
	import cpx_pkg::*;
#(
	parameter int unsigned NUM_LANES = 8,
	parameter int unsigned NUM_DIG   = 2,
	parameter int unsigned MODE_W    = 5,
	parameter int unsigned B_DIG_IDX = 1
) (
	// Clock and reset
	input  wire logic                              core_clk,
	input  wire logic                              rst_n,
	// AXI4-Lite write address and data
	input  wire logic [cpx_pkg::ADDR_W-1:0]        s_axil_awaddr,
	input  wire logic                              s_axil_awvalid,
	output logic                                   s_axil_awready,
	input  wire logic [cpx_pkg::DATA_W-1:0]        s_axil_wdata,
	input  wire logic [cpx_pkg::STRB_W-1:0]        s_axil_wstrb,
	input  wire logic                              s_axil_wvalid,
	output logic                                   s_axil_wready,
	// AXI4-Lite write response
	output logic [1:0]                             s_axil_bresp,
	output logic                                   s_axil_bvalid,
	input  wire logic                              s_axil_bready,
	// AXI4-Lite read
	input  wire logic [cpx_pkg::ADDR_W-1:0]        s_axil_araddr,
	input  wire logic                              s_axil_arvalid,
	output logic                                   s_axil_arready,
	output logic [cpx_pkg::DATA_W-1:0]             s_axil_rdata,
	output logic [1:0]                             s_axil_rresp,
	output logic                                   s_axil_rvalid,
	input  wire logic                              s_axil_rready,
	// Link configuration from neighbouring registers
	input  wire logic                              serialLinkEnable,
	input  wire logic [MODE_W-1:0]                 linkModeSelect,
	input  wire logic [cpx_pkg::TEST_W-1:0]        linkTestSelect,
	input  wire logic [NUM_LANES-1:0]              modeLaneMask,
	input  wire logic                              modeCarriesAbOnLinkA,
	input  wire logic [NUM_DIG-1:0]                digitalChannelBinding,
	// Converter and digital channel power
	output logic                                   convAPowerDown,
	output logic                                   convBPowerDown,
	output logic [NUM_DIG-1:0]                     digChanPowerDown,
	// Serial subsystem power
	output logic                                   serialSubsysPowerDown,
	output logic                                   serPllPowerDown,
	output logic                                   mfClkPowerDown,
	output logic                                   sampleBUndefined,
	// Per-lane controls
	output logic [NUM_LANES-1:0]                   laneLinkClkEn,
	output logic [NUM_LANES-1:0]                   laneSerClkEn,
	output logic [NUM_LANES*cpx_pkg::TEST_W-1:0]   laneTestSelect,
	output logic [MODE_W-1:0]                      laneRateMode
);

	// ==========================================================
	// Declarations
	logic [REG_W-1:0]            chanPd_reg;
	logic [REG_W-1:0]            extraA_reg;
	logic                        lateWrite_reg;
	logic                        wrEn;
	logic [ADDR_W-1:0]           wrAddr;
	logic [DATA_W-1:0]           wrData;
	logic [STRB_W-1:0]           wrStrb;
	logic                        wrHit;
	logic [ADDR_W-1:0]           rdAddr;
	logic [DATA_W-1:0]           rdData;
	logic                        rdHit;
	logic                        wrChanPd;
	logic                        wrExtra;
	logic                        wrStatus;
	logic                        pdA;
	logic                        pdB;
	logic                        subsysPd_next;
	logic [NUM_DIG-1:0]          digPd_next;
	logic                        bUndef_next;
	logic [NUM_LANES-1:0]        extraLaneVec;
	logic [NUM_LANES:0]          serOkChain;
	logic [NUM_LANES-1:0]        linkClk_next;
	logic [NUM_LANES-1:0]        serClk_next;
	logic [NUM_LANES*TEST_W-1:0] laneTest_next;

	// ==========================================================
	// Bus front end
	cpx_axil_slave u_bus (
		.core_clk       (core_clk),
		.rst_n          (rst_n),
		.s_axil_awaddr  (s_axil_awaddr),
		.s_axil_awvalid (s_axil_awvalid),
		.s_axil_awready (s_axil_awready),
		.s_axil_wdata   (s_axil_wdata),
		.s_axil_wstrb   (s_axil_wstrb),
		.s_axil_wvalid  (s_axil_wvalid),
		.s_axil_wready  (s_axil_wready),
		.s_axil_bresp   (s_axil_bresp),
		.s_axil_bvalid  (s_axil_bvalid),
		.s_axil_bready  (s_axil_bready),
		.s_axil_araddr  (s_axil_araddr),
		.s_axil_arvalid (s_axil_arvalid),
		.s_axil_arready (s_axil_arready),
		.s_axil_rdata   (s_axil_rdata),
		.s_axil_rresp   (s_axil_rresp),
		.s_axil_rvalid  (s_axil_rvalid),
		.s_axil_rready  (s_axil_rready),
		.wrEn           (wrEn),
		.wrAddr         (wrAddr),
		.wrData         (wrData),
		.wrStrb         (wrStrb),
		.wrHit          (wrHit),
		.rdAddr         (rdAddr),
		.rdData         (rdData),
		.rdHit          (rdHit)
	);

	// ==========================================================
	// Address decode
	assign wrHit    = (wrAddr == ADDR_CHAN_PD) || (wrAddr == ADDR_EXTRA_A) || (wrAddr == ADDR_STATUS);
	assign wrChanPd = wrEn && (wrAddr == ADDR_CHAN_PD) && wrStrb[0];
	assign wrExtra  = wrEn && (wrAddr == ADDR_EXTRA_A) && wrStrb[0];
	assign wrStatus = wrEn && (wrAddr == ADDR_STATUS) && wrStrb[0];

	always_comb begin
		rdHit  = 1'b1;
		rdData = '0;
		case (rdAddr)
			ADDR_CHAN_PD: rdData[REG_W-1:0] = chanPd_reg;
			ADDR_EXTRA_A: rdData[REG_W-1:0] = extraA_reg;
			ADDR_STATUS: begin
				rdData[STAT_SUBSYS_BIT]  = serialSubsysPowerDown;
				rdData[STAT_B_UNDEF_BIT] = sampleBUndefined;
				rdData[STAT_LATE_WR_BIT] = lateWrite_reg;
			end
			default: rdHit = 1'b0;
		endcase
	end

	// ==========================================================
	// Software registers
	always_ff @(posedge core_clk) begin
		if (!rst_n) begin
			chanPd_reg <= CHAN_PD_RST;
		end else if (wrChanPd) begin
			chanPd_reg <= wrData[REG_W-1:0];
		end
	end

	always_ff @(posedge core_clk) begin
		if (!rst_n) begin
			extraA_reg <= EXTRA_A_RST;
		end else if (wrExtra) begin
			extraA_reg <= wrData[REG_W-1:0];
		end
	end

	// Sticky flag: a change made while the link was running; set beats clear
	always_ff @(posedge core_clk) begin
		if (!rst_n) begin
			lateWrite_reg <= 1'b0;
		end else if ((wrChanPd || wrExtra) && serialLinkEnable) begin
			lateWrite_reg <= 1'b1;
		end else if (wrStatus && wrData[STAT_LATE_WR_BIT]) begin
			lateWrite_reg <= 1'b0;
		end
	end

	// ==========================================================
	// Power-down decode
	assign pdA           = chanPd_reg[PD_CHAN_A_BIT];
	assign pdB           = chanPd_reg[PD_CHAN_B_BIT];
	assign subsysPd_next = pdA & pdB;

	always_comb begin
		for (int i = 0; i < NUM_DIG; i++) begin
			digPd_next[i] = digitalChannelBinding[i] ? pdB : pdA;
		end
	end

	// Link A keeps running; only the B sample slots lose meaning
	assign bUndef_next = modeCarriesAbOnLinkA & digPd_next[B_DIG_IDX] & ~subsysPd_next;

	always_ff @(posedge core_clk) begin
		if (!rst_n) begin
			convAPowerDown        <= 1'b0;
			convBPowerDown        <= 1'b0;
			digChanPowerDown      <= '0;
			serialSubsysPowerDown <= 1'b0;
			serPllPowerDown       <= 1'b0;
			mfClkPowerDown        <= 1'b0;
			sampleBUndefined      <= 1'b0;
		end else begin
			convAPowerDown        <= pdA;
			convBPowerDown        <= pdB;
			digChanPowerDown      <= digPd_next;
			serialSubsysPowerDown <= subsysPd_next;
			serPllPowerDown       <= subsysPd_next;
			mfClkPowerDown        <= subsysPd_next;
			sampleBUndefined      <= bUndef_next;
		end
	end

	// ==========================================================
	// Lane gating
	assign extraLaneVec  = {extraA_reg[NUM_LANES-1:1], 1'b0};
	assign serOkChain[0] = 1'b1;

	for (genvar n = 0; n < NUM_LANES; n++) begin : g_lane
		cpx_lane_gate u_lane (
			.modeUsed    (modeLaneMask[n]),
			.extraLane   (extraLaneVec[n]),
			.extraSer    (extraA_reg[EXTRA_SER_BIT]),
			.subsysPd    (subsysPd_next),
			.testSel     (linkTestSelect),
			.lowerSerOk  (serOkChain[n]),
			.serOkOut    (serOkChain[n+1]),
			.linkClkNext (linkClk_next[n]),
			.serClkNext  (serClk_next[n]),
			.testNext    (laneTest_next[n*TEST_W +: TEST_W])
		);
	end

	always_ff @(posedge core_clk) begin
		if (!rst_n) begin
			laneLinkClkEn  <= '0;
			laneSerClkEn   <= '0;
			laneTestSelect <= '0;
			laneRateMode   <= '0;
		end else begin
			laneLinkClkEn  <= linkClk_next;
			laneSerClkEn   <= serClk_next;
			laneTestSelect <= laneTest_next;
			laneRateMode   <= linkModeSelect;
		end
	end

	// ==========================================================
	// Assertions
	AST_CHAN_B_PD: assert property (@(posedge core_clk) disable iff (!rst_n)
		chanPd_reg[PD_CHAN_B_BIT] |=> convBPowerDown)
		else $error("Channel B not powered down after its bit was set");

	AST_CHAN_A_PD: assert property (@(posedge core_clk) disable iff (!rst_n)
		$rose(chanPd_reg[PD_CHAN_A_BIT]) |=> convAPowerDown ##1 (convAPowerDown == $past(pdA)))
		else $error("Channel A power-down does not follow its bit");

	AST_BIND: assert property (@(posedge core_clk) disable iff (!rst_n)
		$past(rst_n) |-> digChanPowerDown[0] ==
			($past(digitalChannelBinding[0]) ? convBPowerDown : convAPowerDown))
		else $error("Digital channel power-down ignores its binding");

	AST_SUBSYS: assert property (@(posedge core_clk) disable iff (!rst_n)
		(serialSubsysPowerDown && serPllPowerDown && mfClkPowerDown) == (convAPowerDown && convBPowerDown))
		else $error("Serial subsystem power-down does not match both channels down");

	AST_B_UNDEF: assert property (@(posedge core_clk) disable iff (!rst_n)
		sampleBUndefined |-> !serialSubsysPowerDown && digChanPowerDown[B_DIG_IDX])
		else $error("B samples flagged undefined while link A is down");

	AST_EXTRA_CLK: assert property (@(posedge core_clk) disable iff (!rst_n)
		(extraA_reg[3] && !subsysPd_next) |=> laneLinkClkEn[3])
		else $error("Extra lane link clock not enabled");

	AST_EXTRA_SER_OFF: assert property (@(posedge core_clk) disable iff (!rst_n)
		(!extraA_reg[EXTRA_SER_BIT] && !modeLaneMask[1]) |=> !laneSerClkEn[1])
		else $error("Extra serializer clocked with serializer enable clear");

	AST_RAMP: assert property (@(posedge core_clk) disable iff (!rst_n)
		(extraA_reg[2] && !modeLaneMask[2] && linkTestSelect == TEST_ALT_DATA)
		|=> laneTestSelect[2*TEST_W +: TEST_W] == TEST_RAMP)
		else $error("Extra-only lane does not send the octet ramp");

	AST_NO_OVERRIDE: assert property (@(posedge core_clk) disable iff (!rst_n)
		serialSubsysPowerDown |-> (laneLinkClkEn == '0) && (laneSerClkEn == '0))
		else $error("Lane clocks running with the link powered down");

	AST_SER_CHAIN: assert property (@(posedge core_clk) disable iff (!rst_n)
		((laneSerClkEn + NUM_LANES'(1)) & laneSerClkEn) == '0)
		else $error("Serializer clocked with a lower lane disabled");

	AST_RESET_ZERO: assert property (@(posedge core_clk) disable iff (!rst_n)
		$past(!rst_n) |-> (chanPd_reg == CHAN_PD_RST) && (extraA_reg == EXTRA_A_RST))
		else $error("Registers not zero after reset");

	AST_READBACK: assert property (@(posedge core_clk) disable iff (!rst_n)
		wrChanPd |=> chanPd_reg == $past(wrData[REG_W-1:0]))
		else $error("Channel power-down register does not hold written value");

	AST_EXTRA_READBACK: assert property (@(posedge core_clk) disable iff (!rst_n)
		wrExtra |=> extraA_reg == $past(wrData[REG_W-1:0]))
		else $error("Extra-lane register does not hold written value");

	AST_CHAN_A_UP: assert property (@(posedge core_clk) disable iff (!rst_n)
		!chanPd_reg[PD_CHAN_A_BIT] |=> !convAPowerDown)
		else $error("Channel A powered down with its bit clear");

	AST_CHAN_B_UP: assert property (@(posedge core_clk) disable iff (!rst_n)
		!chanPd_reg[PD_CHAN_B_BIT] |=> !convBPowerDown)
		else $error("Channel B powered down with its bit clear");

	AST_DIG_B_BIND: assert property (@(posedge core_clk) disable iff (!rst_n)
		$past(rst_n) |-> digChanPowerDown[B_DIG_IDX] ==
			($past(digitalChannelBinding[B_DIG_IDX]) ? convBPowerDown : convAPowerDown))
		else $error("B digital channel power-down ignores its binding");

	AST_B_UNDEF_SET: assert property (@(posedge core_clk) disable iff (!rst_n)
		(modeCarriesAbOnLinkA && digPd_next[B_DIG_IDX] && !subsysPd_next) |=> sampleBUndefined)
		else $error("B samples not flagged undefined with link A up");

	AST_LINK_CLK_OFF: assert property (@(posedge core_clk) disable iff (!rst_n)
		(!extraA_reg[5] && !modeLaneMask[5]) |=> !laneLinkClkEn[5])
		else $error("Lane link clock running with no request");

	AST_EXTRA_SER_ON: assert property (@(posedge core_clk) disable iff (!rst_n)
		(extraA_reg[EXTRA_SER_BIT] && extraA_reg[1] && modeLaneMask[0] && !subsysPd_next) |=> laneSerClkEn[1])
		else $error("Extra serializer not clocked with serializer enable set");

	AST_RATE_MODE: assert property (@(posedge core_clk) disable iff (!rst_n)
		$past(rst_n) |-> laneRateMode == $past(linkModeSelect))
		else $error("Lane rate mode does not follow link mode");

	AST_USED_LANE_TEST: assert property (@(posedge core_clk) disable iff (!rst_n)
		(rst_n && modeLaneMask[1]) |=> laneTestSelect[TEST_W +: TEST_W] == $past(linkTestSelect))
		else $error("Mode lane does not follow link test select");

	AST_LANE0_UP: assert property (@(posedge core_clk) disable iff (!rst_n)
		(rst_n && modeLaneMask[0] && !subsysPd_next) |=> laneLinkClkEn[0] && laneSerClkEn[0])
		else $error("Mode lane stopped with the link powered up");

	AST_LATE_WRITE: assert property (@(posedge core_clk) disable iff (!rst_n)
		((wrChanPd || wrExtra) && serialLinkEnable) |=> lateWrite_reg)
		else $error("Write during running link not flagged");

endmodule : cpx_top

// ===== tb/cpx_tb_top.sv
// Self-checking bench for the channel power-down and extra-lane register bank
module cpx_tb_top;
	timeunit 1ns;
	timeprecision 1ps;
	import cpx_pkg::*;

	// ==========================================
	// Row table: inputs beside expected outputs
	typedef struct {
		logic [7:0] pd, ex, mask;
		logic [4:0] tst;
		logic [1:0] chanBind;
		logic       ab;
		logic [1:0] dig;
		logic [3:0] pwr;
		logic [7:0] lclk, sclk, ramp;
	} cpx_row_t;
	cpx_row_t rows [6] = '{
		'{8'h01, 8'h00, 8'h03, 5'h00, 2'h2, 1'b1, 2'h1, 4'h1, 8'h03, 8'h03, 8'h00},
		'{8'h02, 8'h0d, 8'h03, 5'h00, 2'h2, 1'b1, 2'h2, 4'h6, 8'h0f, 8'h0f, 8'h0c},
		'{8'h03, 8'h0d, 8'h03, 5'h00, 2'h0, 1'b1, 2'h3, 4'hb, 8'h00, 8'h00, 8'h0c},
		'{8'h00, 8'h21, 8'h03, 5'h05, 2'h0, 1'b0, 2'h0, 4'h0, 8'h23, 8'h03, 8'h20},
		'{8'hfc, 8'h1c, 8'h03, 5'h07, 2'h0, 1'b0, 2'h0, 4'h0, 8'h1f, 8'h03, 8'h00},
		'{8'h00, 8'hff, 8'h01, 5'h00, 2'h0, 1'b0, 2'h0, 4'h0, 8'hff, 8'hff, 8'hfe}};

	// ==========================================
	// Signals
	logic              core_clk = 1'b0, rst_n = 1'b0;
	logic [ADDR_W-1:0] s_axil_awaddr = '0, s_axil_araddr = '0;
	logic              s_axil_awvalid = 1'b0, s_axil_wvalid = 1'b0, s_axil_arvalid = 1'b0;
	logic              s_axil_bready = 1'b0, s_axil_rready = 1'b0;
	logic [DATA_W-1:0] s_axil_wdata = '0, s_axil_rdata;
	logic [STRB_W-1:0] s_axil_wstrb = '1;
	logic              s_axil_awready, s_axil_wready, s_axil_bvalid, s_axil_arready, s_axil_rvalid;
	logic [1:0]        s_axil_bresp, s_axil_rresp, rs;
	logic              serialLinkEnable = 1'b0;
	logic [4:0]        linkModeSelect = '0, linkTestSelect = '0, laneRateMode;
	logic [7:0]        modeLaneMask = '0, laneLinkClkEn, laneSerClkEn;
	logic              modeCarriesAbOnLinkA = 1'b0;
	logic [1:0]        digitalChannelBinding = '0, digChanPowerDown;
	logic              convAPowerDown, convBPowerDown, serialSubsysPowerDown;
	logic              serPllPowerDown, mfClkPowerDown, sampleBUndefined;
	logic [39:0]       laneTestSelect, expTest;
	logic [DATA_W-1:0] rd;
	int                errCount = 0, nChecks = 0;

	always #5 core_clk = ~core_clk;

	cpx_top cpx_top_inst (.core_clk, .rst_n, .s_axil_awaddr, .s_axil_awvalid, .s_axil_awready,
		.s_axil_wdata, .s_axil_wstrb, .s_axil_wvalid, .s_axil_wready, .s_axil_bresp, .s_axil_bvalid,
		.s_axil_bready, .s_axil_araddr, .s_axil_arvalid, .s_axil_arready, .s_axil_rdata,
		.s_axil_rresp, .s_axil_rvalid, .s_axil_rready, .serialLinkEnable, .linkModeSelect,
		.linkTestSelect, .modeLaneMask, .modeCarriesAbOnLinkA, .digitalChannelBinding,
		.convAPowerDown, .convBPowerDown, .digChanPowerDown, .serialSubsysPowerDown,
		.serPllPowerDown, .mfClkPowerDown, .sampleBUndefined, .laneLinkClkEn, .laneSerClkEn,
		.laneTestSelect, .laneRateMode);

	// ==========================================
	// Bus tasks and comparison
	task automatic axw(input logic [ADDR_W-1:0] a, input logic [31:0] d, input logic [3:0] s);
		s_axil_awaddr  <= a;
		s_axil_awvalid <= 1'b1;
		s_axil_wdata   <= d;
		s_axil_wstrb   <= s;
		s_axil_wvalid  <= 1'b1;
		s_axil_bready  <= 1'b1;
		fork
			begin do @(posedge core_clk); while (!s_axil_awready); s_axil_awvalid <= 1'b0; end
			begin do @(posedge core_clk); while (!s_axil_wready); s_axil_wvalid <= 1'b0; end
		join
		do @(posedge core_clk); while (!s_axil_bvalid);
		rs = s_axil_bresp;
		s_axil_bready <= 1'b0;
		// Idle edge before the next request
		@(posedge core_clk);
	endtask : axw

	task automatic axr(input logic [ADDR_W-1:0] a);
		s_axil_araddr  <= a;
		s_axil_arvalid <= 1'b1;
		s_axil_rready  <= 1'b1;
		do @(posedge core_clk); while (!s_axil_arready);
		s_axil_arvalid <= 1'b0;
		do @(posedge core_clk); while (!s_axil_rvalid);
		rd = s_axil_rdata;
		rs = s_axil_rresp;
		s_axil_rready <= 1'b0;
		@(posedge core_clk);
	endtask : axr

	task automatic chk(input string nm, input logic [39:0] exp, input logic [39:0] got);
		nChecks++;
		if (got !== exp) begin
			errCount++;
			$display("[ERR] %s expected %h seen %h", nm, exp, got);
		end
	endtask : chk

	task automatic giveVerdict;
		$display("checks %0d errors %0d", nChecks, errCount);
		if (errCount == 0 && nChecks > 0) $display("Finished cleanly");
		else $display("Finished with errors");
		$finish;
	endtask : giveVerdict

	initial begin
		repeat (5000) @(posedge core_clk);
		errCount++;
		giveVerdict;
	end

	// ==========================================
	// Main sequence
	initial begin
		repeat (8) @(posedge core_clk);
		rst_n <= 1'b1;
		@(posedge core_clk);
		axr(ADDR_CHAN_PD);
		chk("pdReset", 40'h0, rd);
		axr(ADDR_EXTRA_A);
		chk("extraReset", 40'h0, rd);
		// Calibration field and device mode setting lie outside this block
		foreach (rows[i]) begin
			linkModeSelect        <= 5'(i + 3);
			linkTestSelect        <= rows[i].tst;
			modeLaneMask          <= rows[i].mask;
			modeCarriesAbOnLinkA  <= rows[i].ab;
			digitalChannelBinding <= rows[i].chanBind;
			axw(ADDR_CHAN_PD, {24'h0, rows[i].pd}, 4'h1);
			chk("bresp", RESP_OKAY, rs);
			axw(ADDR_EXTRA_A, {24'h0, rows[i].ex}, 4'h1);
			axr(ADDR_CHAN_PD);
			chk("pdRead", rows[i].pd, rd);
			axr(ADDR_EXTRA_A);
			chk("extraRead", rows[i].ex, rd);
			axr(ADDR_STATUS);
			chk("status", {rows[i].pwr[2], rows[i].pwr[3]}, rd);
			for (int n = 0; n < 8; n++) expTest[5*n+:5] = rows[i].ramp[n] ? TEST_RAMP : rows[i].tst;
			chk("power", rows[i].pwr, {serialSubsysPowerDown, sampleBUndefined, convBPowerDown,
				convAPowerDown});
			chk("pllMf", {2{rows[i].pwr[3]}}, {serPllPowerDown, mfClkPowerDown});
			chk("digPd", rows[i].dig, digChanPowerDown);
			chk("linkClk", rows[i].lclk, laneLinkClkEn);
			chk("serClk", rows[i].sclk, laneSerClkEn);
			chk("laneTest", expTest, laneTestSelect);
			chk("rateMode", 5'(i + 3), laneRateMode);
		end
		// Unmapped place, masked write, reset in mid-run
		axr(12'h000);
		chk("unmappedResp", RESP_SLVERR, rs);
		chk("unmappedData", 40'h0, rd);
		axw(12'h004, 32'hff, 4'h1);
		chk("unmappedWr", RESP_SLVERR, rs);
		axw(ADDR_CHAN_PD, 32'hff, 4'h0);
		axr(ADDR_CHAN_PD);
		chk("maskedWr", 40'h0, rd);
		// Write while the link runs: flagged, then cleared
		serialLinkEnable <= 1'b1;
		axw(ADDR_EXTRA_A, 32'h3f, 4'h1);
		serialLinkEnable <= 1'b0;
		axr(ADDR_STATUS);
		chk("lateWrSet", 40'h4, rd);
		axw(ADDR_STATUS, 32'h4, 4'h1);
		axr(ADDR_STATUS);
		chk("lateWrClr", 40'h0, rd);
		rst_n <= 1'b0;
		repeat (8) @(posedge core_clk);
		chk("linkClkInRst", 40'h0, laneLinkClkEn);
		rst_n <= 1'b1;
		@(posedge core_clk);
		axr(ADDR_EXTRA_A);
		chk("extraReRst", 40'h0, rd);
		chk("linkClkRst", 40'h1, laneLinkClkEn);
		giveVerdict;
	end

endmodule : cpx_tb_top
